// ==== logic/asr_host.sv ====
// What this block does
// - Write happens only while select and write enable are both low.
// - Host holds select low at least 12 ns before write end.
// - Host holds write address stable 15 ns before write end.
// - Host drives write data at least 10 ns before write end.
// - Host may drop write data at write end; hold is zero.
// - Host never drives against device output at write start or end.
// - If select stays low after write, pins turn outputs; host avoids conflict.
// - Deselect before supply drop; wait 5 ms after recovery before use.
`timescale 1ns/10ps
`default_nettype none
`include "asr_regs.svh"
module asr_host #(
  parameter int RECOVER_CYC = `ASR_RECOVER_CYC
) (
  input wire logic core_clk_in, // Clock, 100 MHz
  input wire logic reset_in, // Async reset, active high
  input wire logic req_valid_in, // Access request
  input wire logic req_write_in, // 1 write, 0 read
  input wire logic [`ASR_ADDR_W-1:0] req_addr_in, // Byte address
  input wire logic [`ASR_DATA_W-1:0] req_wdata_in, // Write data
  output logic req_ready_out, // Request taken this cycle
  output logic [`ASR_DATA_W-1:0] rdata_out, // Read data
  output logic rdata_valid_out, // Read data pulse
  input wire logic retention_req_in, // Enter low-supply retention
  input wire logic supply_ok_in, // Supply restored after retention
  output logic retention_ok_out, // Safe to drop supply
  output logic chip_sel_n_out, // Chip select, active low
  output logic write_en_n_out, // Write enable, active low
  output logic out_en_n_out, // Output enable, active low
  output logic [`ASR_ADDR_W-1:0] word_address_lines_out, // Address pins
  input wire logic [`ASR_DATA_W-1:0] shared_data_lines_in, // Data pins in
  output logic [`ASR_DATA_W-1:0] shared_data_lines_out, // Data pins out
  output logic shared_data_lines_oe_out // Host drives data pins
);
  localparam int CW = 20;
  asr_pkg::asr_state_t state;
  asr_pkg::asr_state_t next_state;
  logic [`ASR_ADDR_W-1:0] addr;
  logic [`ASR_ADDR_W-1:0] next_addr;
  logic [`ASR_DATA_W-1:0] wdata;
  logic [`ASR_DATA_W-1:0] next_wdata;
  logic [`ASR_DATA_W-1:0] rdata;
  logic [`ASR_DATA_W-1:0] next_rdata;
  logic rvalid;
  logic next_rvalid;
  logic recovering;
  logic next_recovering;
  logic cnt_load;
  logic [CW-1:0] cnt_value;
  logic cnt_done;
  logic next_cs_n;
  logic next_we_n;
  logic next_oe_n;
  logic next_data_oe;

  // Shared phase timer
  asr_counter #(.W(CW)) u_timer (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .load_in(cnt_load),
    .value_in(cnt_value),
    .done_out(cnt_done)
  );

  // Sequencing of standby, read, write and retention phases
  always_comb
  begin
    next_state = state;
    next_addr = addr;
    next_wdata = wdata;
    next_rdata = rdata;
    next_rvalid = 1'b0;
    next_recovering = recovering;
    cnt_load = 1'b0;
    cnt_value = '0;
    unique case (state)
      asr_pkg::ASR_IDLE:
      begin
        if (recovering)
        begin
          if (cnt_done)
            next_recovering = 1'b0;
        end
        else if (retention_req_in)
        begin
          next_state = asr_pkg::ASR_RET;
          cnt_load = 1'b1;
          cnt_value = CW'(`ASR_CYC_CDR);
        end
        else if (req_valid_in && cnt_done)
        begin
          next_addr = req_addr_in;
          next_wdata = req_wdata_in;
          cnt_load = 1'b1;
          if (req_write_in)
          begin
            // Address settles and device drivers float before data goes on
            next_state = asr_pkg::ASR_WR_SETUP;
            cnt_value = CW'(`ASR_CYC_HZ);
          end
          else
          begin
            next_state = asr_pkg::ASR_RD;
            cnt_value = CW'(`ASR_CYC_ACCESS);
          end
        end
      end
      asr_pkg::ASR_RD:
      begin
        if (cnt_done)
        begin
          next_rdata = shared_data_lines_in;
          next_rvalid = 1'b1;
          next_state = asr_pkg::ASR_RD_END;
          cnt_load = 1'b1;
          cnt_value = CW'(`ASR_CYC_HZ);
        end
      end
      asr_pkg::ASR_WR_SETUP:
      begin
        if (cnt_done)
        begin
          next_state = asr_pkg::ASR_WR;
          cnt_load = 1'b1;
          cnt_value = CW'(`ASR_CYC_WP);
        end
      end
      asr_pkg::ASR_WR:
      begin
        if (cnt_done)
        begin
          next_state = asr_pkg::ASR_WR_END;
          cnt_load = 1'b1;
          cnt_value = CW'(1);
        end
      end
      asr_pkg::ASR_RD_END, asr_pkg::ASR_WR_END:
      begin
        // Bus turnaround gap before the next access
        if (cnt_done)
          next_state = asr_pkg::ASR_IDLE;
      end
      asr_pkg::ASR_RET:
      begin
        if (!retention_req_in && supply_ok_in)
        begin
          next_state = asr_pkg::ASR_IDLE;
          next_recovering = 1'b1;
          cnt_load = 1'b1;
          cnt_value = CW'(RECOVER_CYC);
        end
      end
      default:
        next_state = asr_pkg::ASR_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state <= asr_pkg::ASR_IDLE;
      addr <= '0;
      wdata <= '0;
      rdata <= '0;
      rvalid <= 1'b0;
      recovering <= 1'b0;
    end
    else
    begin
      state <= next_state;
      addr <= next_addr;
      wdata <= next_wdata;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
      recovering <= next_recovering;
    end
  end

  // Pin levels for the coming cycle: select low in every access phase, high otherwise
  always_comb
  begin
    next_cs_n = !(next_state == asr_pkg::ASR_RD || next_state == asr_pkg::ASR_WR_SETUP ||
                  next_state == asr_pkg::ASR_WR);
    next_we_n = (next_state != asr_pkg::ASR_WR);
    next_oe_n = (next_state != asr_pkg::ASR_RD);
    // Host drives data only while outputs are disabled and the pulse runs
    next_data_oe = (next_state == asr_pkg::ASR_WR);
  end

  // Strobes leave flip-flops, so no decode glitch can open a stray write
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      chip_sel_n_out <= 1'b1;
      write_en_n_out <= 1'b1;
      out_en_n_out <= 1'b1;
      shared_data_lines_oe_out <= 1'b0;
    end
    else
    begin
      chip_sel_n_out <= next_cs_n;
      write_en_n_out <= next_we_n;
      out_en_n_out <= next_oe_n;
      shared_data_lines_oe_out <= next_data_oe;
    end
  end

  // Address and data pins come straight from their registers
  assign word_address_lines_out = addr;
  assign shared_data_lines_out = wdata;
  assign rdata_out = rdata;
  assign rdata_valid_out = rvalid;
  assign req_ready_out = (state == asr_pkg::ASR_IDLE) && !recovering && !retention_req_in &&
                         cnt_done && req_valid_in;
  assign retention_ok_out = (state == asr_pkg::ASR_RET) && cnt_done;
endmodule
`default_nettype wire

// ==== logic/asr_regs.svh ====
`ifndef ASR_REGS_SVH
`define ASR_REGS_SVH
// Clock period in ns
`define ASR_CLK_PERIOD_NS 10
// Bus widths
`define ASR_ADDR_W 15
`define ASR_DATA_W 8
// Timing figures in ns (recovery in ms), slow grade (covers fast grade too)
`define ASR_T_CYCLE_NS 20
`define ASR_T_ACCESS_NS 20
`define ASR_T_CLZ_NS 3
`define ASR_T_CHZ_NS 10
`define ASR_T_OHZ_NS 10
`define ASR_T_WHZ_NS 10
`define ASR_T_CW_NS 12
`define ASR_T_AW_NS 15
`define ASR_T_DW_NS 10
`define ASR_T_DH_NS 0
`define ASR_T_OW_NS 3
`define ASR_T_CDR_NS 0
`define ASR_T_RECOVER_MS 5
// Cycle counts: least times round up, never below one
`define ASR_CEIL(ns) ((((ns) + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS) < 1 ? 1 : \
  (((ns) + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS))
`define ASR_CYC_ACCESS (`ASR_CEIL(`ASR_T_ACCESS_NS) + 1)
`define ASR_CYC_HZ `ASR_CEIL(`ASR_T_CHZ_NS)
`define ASR_CYC_WP `ASR_CEIL(`ASR_T_AW_NS)
`define ASR_CYC_CDR `ASR_CEIL(`ASR_T_CDR_NS)
`define ASR_RECOVER_CYC 500000
`endif

// ==== logic/asr_pkg.sv ====
`default_nettype none
package asr_pkg;
  typedef enum logic [6:0] {
    ASR_IDLE = 7'h01,
    ASR_RD = 7'h02,
    ASR_RD_END = 7'h04,
    ASR_WR_SETUP = 7'h08,
    ASR_WR = 7'h10,
    ASR_WR_END = 7'h20,
    ASR_RET = 7'h40
  } asr_state_t;
endpackage
`default_nettype wire

// ==== logic/asr_counter.sv ====
`timescale 1ns/10ps
`default_nettype none
// Loadable down counter used for every timed phase
module asr_counter #(
  parameter int W = 20
) (
  input wire logic core_clk_in, // Clock
  input wire logic reset_in, // Async reset, active high
  input wire logic load_in, // Load pulse
  input wire logic [W-1:0] value_in, // Value to load
  output logic done_out // Count has reached zero
);
  logic [W-1:0] count;
  logic [W-1:0] next_count;
  // Next count
  always_comb
  begin
    next_count = count;
    if (load_in)
      next_count = value_in;
    else if (count != '0)
      next_count = count - W'(1);
  end
  // Register
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
      count <= '0;
    else
      count <= next_count;
  end
  // Done looks only at the count, so a load that depends on it forms no loop
  assign done_out = (count == '0);
endmodule
`default_nettype wire

// ==== test/asr_host_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
// Pin-side protocol checks
module asr_host_asserts #(
  parameter int RECOVER_CYC = 20
) (
  input wire logic core_clk_in, // Clock
  input wire logic reset_in, // Reset
  input wire logic req_valid_in, // Request
  input wire logic req_write_in, // Write flag
  input wire logic req_ready_out, // Taken
  input wire logic rdata_valid_out, // Read pulse
  input wire logic retention_req_in, // Retention ask
  input wire logic retention_ok_out, // Retention grant
  input wire logic chip_sel_n_out, // Select
  input wire logic write_en_n_out, // Write enable
  input wire logic out_en_n_out, // Output enable
  input wire logic [14:0] word_address_lines_out, // Address
  input wire logic shared_data_lines_oe_out // Host drives
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  // Strobe and data window relations
  we_sel_a: assert property (!write_en_n_out |-> !chip_sel_n_out) else $error("we w/o sel");
  drive_win_a: assert property (shared_data_lines_oe_out |-> !write_en_n_out && !chip_sel_n_out)
    else $error("drive window");
  we_width_a: assert property ($fell(write_en_n_out) |-> !write_en_n_out[*2]) else $error("we width");
  addr_setup_a: assert property ($fell(write_en_n_out) |->
    !$past(chip_sel_n_out) && $stable(word_address_lines_out)) else $error("addr setup");
  addr_hold_a: assert property (!chip_sel_n_out && !$past(chip_sel_n_out) |-> $stable(word_address_lines_out))
    else $error("addr hold");
  read_oe_a: assert property (!out_en_n_out |-> write_en_n_out && !shared_data_lines_oe_out)
    else $error("oe clash");
  ret_desel_a: assert property (retention_ok_out |-> chip_sel_n_out) else $error("ret sel");
  ready_gate_a: assert property (req_ready_out |-> !retention_req_in && chip_sel_n_out) else $error("ready");
  read_lat_a: assert property (req_valid_in && req_ready_out && !req_write_in |-> ##5 rdata_valid_out)
    else $error("read lat");
  // Main scenarios seen
  c_read: cover property (req_valid_in && req_ready_out && !req_write_in);
  c_write: cover property ($fell(write_en_n_out));
  c_ret: cover property (retention_ok_out);
endmodule
bind asr_host asr_host_asserts #(.RECOVER_CYC(RECOVER_CYC)) u_chk (.core_clk_in, .reset_in, .req_valid_in,
  .req_write_in, .req_ready_out, .rdata_valid_out, .retention_req_in, .retention_ok_out, .chip_sel_n_out,
  .write_en_n_out, .out_en_n_out, .word_address_lines_out, .shared_data_lines_oe_out);
`default_nettype wire

// ==== test/asr_sram_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// Behavioural static byte array behind the pins
module asr_sram_model (
  input wire logic cs_n_in, // Select
  input wire logic we_n_in, // Write enable
  input wire logic oe_n_in, // Output enable
  input wire logic [14:0] addr_in, // Address
  input wire logic [7:0] data_in, // Bus level
  output logic [7:0] data_out, // Driven byte
  output logic drive_out // Device drives bus
);
  // Static contents, no refresh, kept while deselected
  logic [7:0] mem [0:32767];
  wire wr = !cs_n_in && !we_n_in;
  // Store at the end of the overlap
  always @(negedge wr) mem[addr_in] <= data_in;
  // Read decode; low-Z late, never while writing
  assign #3 drive_out = !cs_n_in && !oe_n_in && we_n_in;
  // Access delay, old data holds meanwhile
  assign #15 data_out = mem[addr_in];
endmodule
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench for the pin-side host
module tb;
  localparam int REC = 20;
  logic core_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic req_valid_in = 1'b0;
  logic req_write_in = 1'b0;
  logic [14:0] req_addr_in = 15'h0000;
  logic [7:0] req_wdata_in = 8'h00;
  logic retention_req_in = 1'b0;
  logic supply_ok_in = 1'b1;
  logic [7:0] last = 8'h00;
  logic req_ready_out, rdata_valid_out, retention_ok_out, chip_sel_n_out, write_en_n_out, out_en_n_out;
  logic shared_data_lines_oe_out, drv;
  logic [7:0] rdata_out, shared_data_lines_out, q;
  logic [14:0] word_address_lines_out;
  wire [7:0] shared_data_lines_in;
  int error_cnt = 0;
  int total_checks = 0;
  // Clock
  always #5 core_clk_in = ~core_clk_in;
  // Bus level: host, device, else flips each cycle
  assign #1 shared_data_lines_in = shared_data_lines_oe_out ? shared_data_lines_out : (drv ? q : ~last);
  always @(posedge core_clk_in) last <= shared_data_lines_in;
  asr_host #(.RECOVER_CYC(REC)) i_dut (.core_clk_in, .reset_in, .req_valid_in, .req_write_in, .req_addr_in,
    .req_wdata_in, .req_ready_out, .rdata_out, .rdata_valid_out, .retention_req_in, .supply_ok_in,
    .retention_ok_out, .chip_sel_n_out, .write_en_n_out, .out_en_n_out, .word_address_lines_out,
    .shared_data_lines_in, .shared_data_lines_out, .shared_data_lines_oe_out);
  asr_sram_model i_mem (.cs_n_in(chip_sel_n_out), .we_n_in(write_en_n_out), .oe_n_in(out_en_n_out),
    .addr_in(word_address_lines_out), .data_in(shared_data_lines_in), .data_out(q), .drive_out(drv));
  // Compare and count
  task automatic cmp(input string s, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (e !== g)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask
  // Request held until taken; k counts cycles waited, n cycles to read data
  task automatic req(input logic w, input logic [14:0] a, input logic [7:0] d, output int k, output int n);
    k = 0;
    n = 0;
    @(negedge core_clk_in);
    req_write_in = w;
    req_addr_in = a;
    req_wdata_in = d;
    req_valid_in = 1'b1;
    #1;
    while (req_ready_out !== 1'b1 && k < 40)
    begin
      @(negedge core_clk_in);
      #1;
      k++;
    end
    cmp("req_taken", 16'h0001, {15'h0000, req_ready_out});
    @(negedge core_clk_in);
    req_valid_in = 1'b0;
    while (!w && rdata_valid_out !== 1'b1 && n < 9)
    begin
      @(negedge core_clk_in);
      n++;
    end
  endtask
  // Back-to-back writes at both array ends, read back
  task automatic t_rw;
    logic [14:0] ad [3] = '{15'h0000, 15'h7fff, 15'h2aaa};
    logic [7:0] dt [3] = '{8'h55, 8'haa, 8'h0f};
    int k, n;
    for (int i = 0; i < 3; i++)
      req(1'b1, ad[i], dt[i], k, n);
    for (int i = 0; i < 3; i++)
    begin
      req(1'b0, ad[i], 8'h00, k, n);
      cmp("rd_lat", 16'h0004, 16'(n));
      cmp("rd_data", {8'h00, dt[i]}, {8'h00, rdata_out});
    end
  endtask
  // Retention refuses work, exit waits recovery, data survives
  task automatic t_ret;
    int k, n;
    retention_req_in = 1'b1;
    supply_ok_in = 1'b0;
    req_valid_in = 1'b1;
    k = 0;
    while (retention_ok_out !== 1'b1 && k < 10)
    begin
      @(negedge core_clk_in);
      k++;
    end
    cmp("ret_ok", 16'h0001, {15'h0000, retention_ok_out});
    cmp("ret_cs_n", 16'h0001, {15'h0000, chip_sel_n_out});
    cmp("refused", 16'h0000, {15'h0000, req_ready_out});
    req_valid_in = 1'b0;
    retention_req_in = 1'b0;
    @(negedge core_clk_in);
    supply_ok_in = 1'b1;
    req(1'b0, 15'h7fff, 8'h00, k, n);
    cmp("recover", 16'h0001, {15'h0000, k >= REC});
    cmp("kept", 16'h00aa, {8'h00, rdata_out});
  endtask
  // Verdict and end of run
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Reset then scenarios
  initial
  begin
    repeat (2) @(negedge core_clk_in);
    reset_in = 1'b0;
    t_rw();
    t_ret();
    summarize();
  end
  // Watchdog
  initial
  begin
    #20000;
    error_cnt++;
    summarize();
  end
endmodule
`default_nettype wire
